// *** timer_event_counter_pkg.sv ***
// Constants and types shared by the timer and event counter.
package timer_event_counter_pkg;
    localparam int COUNT_WIDTH = 8;
    localparam int PRESCALE_WIDTH = 5;
    localparam int STATES_PER_CYCLE = 10;
    localparam int CLOCKS_PER_STATE = 3;
    localparam int CLOCKS_PER_INSTRUCTION = STATES_PER_CYCLE * CLOCKS_PER_STATE;
    localparam int TICK_WIDTH = 5;
    localparam logic [TICK_WIDTH-1:0] TICK_LAST = 5'h1D;
    localparam logic [PRESCALE_WIDTH-1:0] PRESCALE_RESET = 5'h00;
    localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 8'hFF;

    typedef enum logic [1:0] {
        MODE_STOPPED = 2'b00,
        MODE_TIMER = 2'b01,
        MODE_EVENT = 2'b10
    } count_mode_t;
endpackage

// *** timer_event_counter.sv ***
// Eight-bit timer and event counter with prescaler and overflow flag.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module timer_event_counter
    import timer_event_counter_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic start_timer_instruction,
    input wire logic start_event_count_instruction,
    input wire logic halt_counting_instruction,
    input wire logic load_counter_instruction,
    input wire logic read_counter_instruction,
    input wire logic jump_on_overflow_instruction,
    input wire logic [COUNT_WIDTH-1:0] accumulator,
    input wire logic event_input_pin,
    output logic [COUNT_WIDTH-1:0] read_data,
    output logic overflow_flag,
    output logic jump_taken,
    output logic running_timer,
    output logic running_event
);
    count_mode_t mode;
    logic [TICK_WIDTH-1:0] tick_count;
    logic [PRESCALE_WIDTH-1:0] prescale;
    logic [COUNT_WIDTH-1:0] count;
    logic event_prev;
    logic instruction_tick;
    logic prescale_wrap;
    logic event_fall;
    logic increment;
    logic wrap;

    ////////////////////////////////////////////////////////////////////////////
    // Mode control. Halt wins over a start issued in the same cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode <= MODE_STOPPED;
        end else if (halt_counting_instruction) begin
            mode <= MODE_STOPPED;
        end else if (start_timer_instruction) begin
            mode <= MODE_TIMER;
        end else if (start_event_count_instruction) begin
            mode <= MODE_EVENT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction-cycle divider: one tick every ten states of three clocks.
    assign instruction_tick = (tick_count == TICK_LAST);

    always_ff @(posedge clk) begin
        if (!resetn || start_timer_instruction || instruction_tick) begin
            tick_count <= '0;
        end else begin
            tick_count <= tick_count + 5'h01;
        end
    end

    assign prescale_wrap = instruction_tick && (prescale == 5'h1F);

    always_ff @(posedge clk) begin
        if (!resetn || start_timer_instruction) begin
            prescale <= PRESCALE_RESET;
        end else if (mode == MODE_TIMER && instruction_tick) begin
            prescale <= prescale + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event edge detector. The pin is taken as synchronous, so one sample
    // register suffices; it runs even while stopped so that starting does not
    // see a stale level as an edge.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            event_prev <= 1'b0;
        end else begin
            event_prev <= event_input_pin;
        end
    end

    assign event_fall = event_prev && !event_input_pin;

    ////////////////////////////////////////////////////////////////////////////
    // Counter. The count has no reset so that it survives one.
    always_comb begin
        unique case (mode)
            MODE_TIMER: increment = prescale_wrap;
            MODE_EVENT: increment = event_fall;
            default: increment = 1'b0;
        endcase
    end

    assign wrap = increment && (count == COUNT_MAX);

    always_ff @(posedge clk) begin
        if (load_counter_instruction) begin
            count <= accumulator;
        end else if (increment) begin
            count <= count + 8'h01;
        end
    end

    // Read capture leaves the counting path untouched.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            read_data <= 8'h00;
        end else if (read_counter_instruction) begin
            read_data <= count;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag: a wrap in the test cycle survives the clear.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (jump_on_overflow_instruction) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            jump_taken <= 1'b0;
        end else begin
            jump_taken <= jump_on_overflow_instruction && overflow_flag;
        end
    end

    assign running_timer = (mode == MODE_TIMER);
    assign running_event = (mode == MODE_EVENT);
endmodule
`default_nettype wire

// *** timer_event_counter_chk.sv ***
// Port assertions for the timer and event counter.
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_chk
    import timer_event_counter_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic start_timer_instruction,
    input wire logic start_event_count_instruction,
    input wire logic halt_counting_instruction,
    input wire logic load_counter_instruction,
    input wire logic read_counter_instruction,
    input wire logic jump_on_overflow_instruction,
    input wire logic overflow_flag,
    input wire logic jump_taken,
    input wire logic running_timer,
    input wire logic running_event,
    input wire logic [COUNT_WIDTH-1:0] accumulator,
    input wire logic [COUNT_WIDTH-1:0] read_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic st = start_timer_instruction, ev = start_event_count_instruction, hl = halt_counting_instruction;
    wire logic jp = jump_on_overflow_instruction, off = !running_timer && !running_event, calm = off && !st && !ev;
    sequence load_read; load_counter_instruction && calm ##1 read_counter_instruction && off; endsequence
    halt_stop_a: assert property (hl |=> off) else $error("halt");
    stay_off_a: assert property (calm |=> off) else $error("restart");
    timer_go_a: assert property (st && !hl |=> running_timer) else $error("timer");
    event_go_a: assert property (ev && !st && !hl |=> running_event) else $error("event");
    load_back_a: assert property (load_read |=> read_data == $past(accumulator, 2)) else $error("load");
    jump_hit_a: assert property (jp && overflow_flag |=> jump_taken) else $error("jump");
    flag_clear_a: assert property (jp && calm |=> !overflow_flag) else $error("clear");
    flag_hold_a: assert property (calm && !jp |=> $stable(overflow_flag)) else $error("flag");
endmodule
`default_nettype wire

// *** event_source.sv ***
// Event source that gives one falling edge per request.
`timescale 1ns/10ps
`default_nettype none
module event_source(
    input wire logic clk,
    input wire logic fire,
    output logic pin
);
    logic [6:0] left = 7'h00;
    // Ninety busy clocks keep edges three instruction cycles apart.
    always_ff @(posedge clk) left <= (fire && left == 7'h00) ? 7'h5A : left - {6'h00, left != 7'h00};
    assign pin = left <= 7'h2D;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench driving the counter beside the event source.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0, resetn = 0, fire = 0, pin, flag, jt, rt, re;
    logic [7:0] acc = 8'h00, rdat;
    logic [5:0] ins = 6'h00;
    int mismatches = 0, n_tests = 0;
    timer_event_counter i_dut(.clk, .resetn, .start_timer_instruction(ins[0]), .start_event_count_instruction(ins[1]),
        .halt_counting_instruction(ins[2]), .load_counter_instruction(ins[3]), .read_counter_instruction(ins[4]),
        .jump_on_overflow_instruction(ins[5]), .accumulator(acc), .event_input_pin(pin), .read_data(rdat),
        .overflow_flag(flag), .jump_taken(jt), .running_timer(rt), .running_event(re));
    event_source i_src(.clk, .fire, .pin);
    always #20 clk = !clk;
    task automatic op(input logic [5:0] b);
        @(negedge clk) ins = b;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] exp);
        op(6'h10);
        op(6'h00);
        chk(rdat, exp);
    endtask
    task automatic ev(input int n);
        repeat (n) begin
            @(negedge clk) {ins, fire} = 7'h01;
            @(negedge clk) fire = 0;
            repeat (95) @(negedge clk);
        end
    endtask
    task automatic test_event;
        acc = 8'hFD;
        op(6'h08);
        rd(8'hFD);
        op(6'h02);
        ev(3);
        rd(8'h00);
        chk({7'h00, flag}, 8'h01);
        op(6'h20);
        op(6'h00);
        chk({6'h00, flag, jt}, 8'h01);
        op(6'h04);
        ev(1);
        rd(8'h00);
    endtask
    task automatic test_timer;
        acc = 8'hFE;
        op(6'h08);
        op(6'h01);
        op(6'h00);
        repeat (900) @(negedge clk);
        rd(8'hFE);
        repeat (100) @(negedge clk);
        rd(8'hFF);
        op(6'h02);
        rd(8'hFF);
        @(negedge clk) resetn = 0;
        @(negedge clk) resetn = 1;
        rd(8'hFF);
    endtask
    task automatic finish_test;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1;
        test_event;
        test_timer;
        finish_test;
    end
    // A hung handshake must still reach the verdict.
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        finish_test;
    end
endmodule
bind timer_event_counter timer_event_counter_chk i_chk(.*);
`default_nettype wire
